/* File: common/period_timer_pkg.sv */
/*
 * Constants, mode encodings and carrier structs for the 8-bit period timer.
 * Assumes a single 125 MHz clock domain; all inputs synchronous to it.
 */
package period_timer_pkg;
	// ---------------------------------------------------------------
	// widths and reset values
	// ---------------------------------------------------------------
	localparam int COUNT_W = 8;
	localparam int PRE_W = 7;
	localparam int POST_W = 4;
	localparam int MODE_W = 5;
	localparam int SRC_W = 4;
	localparam int SRC_N = 16;
	localparam logic [COUNT_W-1:0] COUNT_RESET = 8'h00;
	localparam logic [COUNT_W-1:0] LIMIT_RESET = 8'hFF;
	localparam logic [COUNT_W-1:0] COUNT_ONE = 8'h01;
	localparam logic [PRE_W-1:0] PRE_ZERO = 7'h00;
	localparam logic [PRE_W-1:0] PRE_ONE = 7'h01;
	localparam logic [POST_W-1:0] POST_ZERO = 4'h0;
	localparam logic [POST_W-1:0] POST_ONE = 4'h1;
	// level reset acts after this many timer ticks of steady level
	localparam logic [1:0] LEVEL_DELAY = 2'h2;
	localparam logic [1:0] LEVEL_ZERO = 2'h0;
	localparam logic [1:0] LEVEL_ONE = 2'h1;

	// ---------------------------------------------------------------
	// mode field layout
	// ---------------------------------------------------------------
	localparam logic [1:0] GRP_FREE = 2'h0;
	localparam logic [1:0] GRP_ONESHOT = 2'h1;
	localparam logic [1:0] GRP_MONO = 2'h2;
	localparam logic [1:0] GRP_RSVD = 2'h3;

	typedef enum logic [1:0] {
		TRIG_NONE,
		TRIG_RISE,
		TRIG_FALL,
		TRIG_ANY
	} trig_e;

	typedef struct packed {
		logic run;
		logic [MODE_W-1:0] mode;
		logic [2:0] prescale;
		logic [POST_W-1:0] postscale;
		logic [SRC_W-1:0] source;
		logic irqEnable;
	} ctrl_s;

	typedef struct packed {
		logic countWrite;
		logic [COUNT_W-1:0] countData;
		logic limitWrite;
		logic [COUNT_W-1:0] limitData;
		logic ctrlWrite;
		logic runClear;
		logic flagClear;
	} sw_s;
endpackage : period_timer_pkg

/* File: design/timer_prescaler.sv */
/*
 * Prescaler: divides the incoming clock by 2**select, select 0..7 (1:1..1:128).
 * Assumes clr is pulsed whenever the prescaler must restart its count.
 */
`timescale 1ns/100ps
module timer_prescaler (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic clr,
	input wire logic [2:0] select,
	output logic tick
);
	logic [period_timer_pkg::PRE_W-1:0] preCount;
	logic [period_timer_pkg::PRE_W-1:0] preMask;

	assign preMask = period_timer_pkg::PRE_W'((8'h01 << select) - 8'h01);
	assign tick = ((preCount & preMask) == preMask) && !clr;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			preCount <= period_timer_pkg::PRE_ZERO;
		end else if (clr) begin
			preCount <= period_timer_pkg::PRE_ZERO;
		end else begin
			preCount <= preCount + period_timer_pkg::PRE_ONE;
		end
	end
endmodule : timer_prescaler

/* File: design/timer_postscaler.sv */
/*
 * Postscaler: counts period matches and pulses on the selected ratio.
 * Assumes match is high for one tick-qualified clock per period event.
 */
`timescale 1ns/100ps
module timer_postscaler (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic clr,
	input wire logic match,
	input wire logic [period_timer_pkg::POST_W-1:0] select,
	output logic pulse
);
	logic [period_timer_pkg::POST_W-1:0] postCount;
	logic hit;

	// select n means a ratio of 1:(n+1)
	assign hit = match && (postCount == select);

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			postCount <= period_timer_pkg::POST_ZERO;
		end else if (clr || hit) begin
			postCount <= period_timer_pkg::POST_ZERO;
		end else if (match) begin
			postCount <= postCount + period_timer_pkg::POST_ONE;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pulse <= 1'b0;
		end else begin
			pulse <= hit && !clr;
		end
	end
endmodule : timer_postscaler

/* File: design/period_timer_with_hw_limit.sv */
/*
 * Top of the 8-bit period timer with hardware limit modes.
 * Assumes software strobes arrive as one-cycle pulses on swCmd.
 */
// Summary of operation
// - count advances per prescaled tick when permitted
// - match with limit pulses, reloads zero next
// - reset clears count, limit goes all ones
// - scalers cleared on count and control writes, reset, ext reset
// - postscaler pulse one clock wide, then clears, except free modes at 1:1 with limit and postscale zero
// - one-shot clears run bit at match
// - one-shot stops count at zero, run cleared
// - monostable stops at zero, run kept
// - gate holds count, resumes from held value
// - source select and five-bit mode steer input
// - debug freeze ignores external triggers
// - free modes 000-010 software and hardware gates
// - free modes 011-111 edge and level resets
// - one-shot 000-011 software or edge start
// - one-shot 100-111 edge start with reset
// - monostable 001-011 edge start, 000 reserved
// - level one-shot 10110, 10111; others reserved
// - edge modes need fresh edge after rerun
// - interrupt flag on postscale match, enable gated
// - flag set after sync delay, software clears
// - count and limit are eight bits
// - prescaler ratio one to one twenty-eight
// - level reset acts two ticks after active
// - level reset ignored while run clear
`timescale 1ns/100ps
module period_timer_with_hw_limit (
	input wire logic clk,
	input wire logic rst_b,
	input wire period_timer_pkg::ctrl_s ctrl,
	input wire period_timer_pkg::sw_s swCmd,
	input wire logic [period_timer_pkg::SRC_N-1:0] ext_reset_sources,
	input wire logic debugFreeze,
	output logic [period_timer_pkg::COUNT_W-1:0] period_count,
	output logic [period_timer_pkg::COUNT_W-1:0] period_limit,
	output logic timer_run_bit,
	output logic postscaled_pulse,
	output logic period_irq_flag,
	output logic period_irq
);
	// ---------------------------------------------------------------
	// mode decode
	// ---------------------------------------------------------------
	logic [1:0] grp;
	logic [2:0] sub;
	logic reserved;
	logic gateNeed;
	logic gatePol;
	logic levelReset;
	logic levelPol;
	logic stopAtMatch;
	logic clearRunAtMatch;
	logic needStart;
	logic levelStart;
	period_timer_pkg::trig_e startTrig;
	period_timer_pkg::trig_e resetTrig;

	assign grp = ctrl.mode[4:3];
	assign sub = ctrl.mode[2:0];

	always_comb begin
		reserved = 1'b0;
		gateNeed = 1'b0;
		gatePol = 1'b0;
		levelReset = 1'b0;
		levelPol = 1'b0;
		stopAtMatch = 1'b0;
		clearRunAtMatch = 1'b0;
		needStart = 1'b0;
		levelStart = 1'b0;
		startTrig = period_timer_pkg::TRIG_NONE;
		resetTrig = period_timer_pkg::TRIG_NONE;
		case (grp)
			period_timer_pkg::GRP_FREE: begin
				case (sub)
					3'h1: begin gateNeed = 1'b1; gatePol = 1'b1; end
					3'h2: begin gateNeed = 1'b1; gatePol = 1'b0; end
					3'h3: resetTrig = period_timer_pkg::TRIG_ANY;
					3'h4: resetTrig = period_timer_pkg::TRIG_RISE;
					3'h5: resetTrig = period_timer_pkg::TRIG_FALL;
					3'h6: begin levelReset = 1'b1; levelPol = 1'b0; end
					3'h7: begin levelReset = 1'b1; levelPol = 1'b1; end
					default: ;
				endcase
			end
			period_timer_pkg::GRP_ONESHOT: begin
				stopAtMatch = 1'b1;
				clearRunAtMatch = 1'b1;
				needStart = (sub != 3'h0);
				case (sub)
					3'h1: startTrig = period_timer_pkg::TRIG_RISE;
					3'h2: startTrig = period_timer_pkg::TRIG_FALL;
					3'h3: startTrig = period_timer_pkg::TRIG_ANY;
					3'h4: begin
						startTrig = period_timer_pkg::TRIG_RISE;
						resetTrig = period_timer_pkg::TRIG_RISE;
					end
					3'h5: begin
						startTrig = period_timer_pkg::TRIG_FALL;
						resetTrig = period_timer_pkg::TRIG_FALL;
					end
					3'h6: begin
						startTrig = period_timer_pkg::TRIG_RISE;
						levelReset = 1'b1;
						levelPol = 1'b0;
					end
					3'h7: begin
						startTrig = period_timer_pkg::TRIG_FALL;
						levelReset = 1'b1;
						levelPol = 1'b1;
					end
					default: ;
				endcase
			end
			period_timer_pkg::GRP_MONO: begin
				case (sub)
					3'h1, 3'h2, 3'h3: begin
						stopAtMatch = 1'b1;
						needStart = 1'b1;
						startTrig = (sub == 3'h1) ? period_timer_pkg::TRIG_RISE :
							(sub == 3'h2) ? period_timer_pkg::TRIG_FALL :
							period_timer_pkg::TRIG_ANY;
					end
					3'h6, 3'h7: begin
						stopAtMatch = 1'b1;
						clearRunAtMatch = 1'b1;
						needStart = 1'b1;
						levelStart = 1'b1;
						levelReset = 1'b1;
						levelPol = sub[0];
					end
					default: reserved = 1'b1;
				endcase
			end
			default: reserved = 1'b1;
		endcase
	end

	// ---------------------------------------------------------------
	// external input select and edge detection
	// ---------------------------------------------------------------
	logic extIn;
	logic extPrev;
	logic rise;
	logic fall;
	logic startEdge;
	logic resetEdge;
	logic levelActive;
	logic [1:0] levelCount;
	logic levelHit;

	assign extIn = ext_reset_sources[ctrl.source];

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			extPrev <= 1'b0;
		end else begin
			extPrev <= extIn;
		end
	end

	// freeze masks every trigger, edges and levels alike
	assign rise = extIn && !extPrev && !debugFreeze;
	assign fall = !extIn && extPrev && !debugFreeze;

	function automatic logic trigHit(period_timer_pkg::trig_e t, logic r, logic f);
		case (t)
			period_timer_pkg::TRIG_RISE: trigHit = r;
			period_timer_pkg::TRIG_FALL: trigHit = f;
			period_timer_pkg::TRIG_ANY: trigHit = r || f;
			default: trigHit = 1'b0;
		endcase
	endfunction : trigHit

	assign startEdge = trigHit(startTrig, rise, fall);
	assign resetEdge = trigHit(resetTrig, rise, fall) && timer_run_bit;

	// level reset ignored while stopped by software
	assign levelActive = levelReset && timer_run_bit && !debugFreeze &&
		(extIn == levelPol);

	// ---------------------------------------------------------------
	// prescaler and tick
	// ---------------------------------------------------------------
	logic tick;
	logic scalerClear;
	logic hwReset;
	logic match;

	localparam logic [1:0] LEVEL_DELAY_L = period_timer_pkg::LEVEL_DELAY;
	assign levelHit = levelActive && (levelCount == LEVEL_DELAY_L);

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			levelCount <= period_timer_pkg::LEVEL_ZERO;
		end else if (!levelActive) begin
			levelCount <= period_timer_pkg::LEVEL_ZERO;
		end else if (tick && levelCount != LEVEL_DELAY_L) begin
			levelCount <= levelCount + period_timer_pkg::LEVEL_ONE;
		end
	end

	assign hwReset = resetEdge || levelHit;
	assign scalerClear = swCmd.countWrite || swCmd.ctrlWrite || hwReset;

	timer_prescaler u_prescaler (
		.clk(clk),
		.rst_b(rst_b),
		.clr(scalerClear),
		.select(ctrl.prescale),
		.tick(tick)
	);

	// ---------------------------------------------------------------
	// start qualification and run bit
	// ---------------------------------------------------------------
	logic armed;
	logic gateOk;
	logic counting;

	// armed marks a started cycle; dropped when run clears so a fresh edge is needed
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			armed <= 1'b0;
		end else if (!timer_run_bit || reserved) begin
			armed <= 1'b0;
		end else if (tick && match && stopAtMatch) begin
			armed <= 1'b0;
		end else if (startEdge || (levelStart && extIn == !levelPol && !debugFreeze)) begin
			armed <= 1'b1;
		end
	end

	assign gateOk = !gateNeed || (extIn == gatePol);
	assign counting = timer_run_bit && !reserved && gateOk &&
		(!needStart || armed) && !levelActive;

	// software set, hardware clears in one-shot; hardware clear wins
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			timer_run_bit <= 1'b0;
		end else if (tick && counting && match && clearRunAtMatch) begin
			timer_run_bit <= 1'b0;
		end else if (swCmd.runClear) begin
			timer_run_bit <= 1'b0;
		end else if (swCmd.ctrlWrite) begin
			timer_run_bit <= ctrl.run;
		end
	end

	// ---------------------------------------------------------------
	// count and limit
	// ---------------------------------------------------------------
	assign match = (period_count == period_limit);

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			period_count <= period_timer_pkg::COUNT_RESET;
		end else if (swCmd.countWrite) begin
			period_count <= swCmd.countData;
		end else if (hwReset) begin
			period_count <= period_timer_pkg::COUNT_RESET;
		end else if (tick && counting) begin
			if (match) begin
				period_count <= period_timer_pkg::COUNT_RESET;
			end else begin
				period_count <= period_count + period_timer_pkg::COUNT_ONE;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			period_limit <= period_timer_pkg::LIMIT_RESET;
		end else if (swCmd.limitWrite) begin
			period_limit <= swCmd.limitData;
		end
	end

	// ---------------------------------------------------------------
	// postscaler and interrupt flag
	// ---------------------------------------------------------------
	logic postPulse;
	logic flagSync;

	timer_postscaler u_postscaler (
		.clk(clk),
		.rst_b(rst_b),
		.clr(scalerClear),
		.match(tick && counting && match),
		.select(ctrl.postscale),
		.pulse(postPulse)
	);

	// pulse lasts one clock, except free modes at 1:1 with limit and postscale zero; widened to a tick would need a second latch
	assign postscaled_pulse = postPulse;

	// one-stage sync delay stands for the instruction-clock resync
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			flagSync <= 1'b0;
		end else begin
			flagSync <= postPulse;
		end
	end

	// set wins over a clear in the same cycle
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			period_irq_flag <= 1'b0;
		end else if (flagSync) begin
			period_irq_flag <= 1'b1;
		end else if (swCmd.flagClear) begin
			period_irq_flag <= 1'b0;
		end
	end

	assign period_irq = period_irq_flag && ctrl.irqEnable;

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	a_count_reload: assert property (@(posedge clk) disable iff (!rst_b)
		(tick && counting && match && !swCmd.countWrite && !hwReset)
		|=> period_count == period_timer_pkg::COUNT_RESET)
		else $error("count did not reload after match");
	a_count_step: assert property (@(posedge clk) disable iff (!rst_b)
		(tick && counting && !match && !swCmd.countWrite && !hwReset)
		|=> period_count == $past(period_count) + period_timer_pkg::COUNT_ONE)
		else $error("count did not step");
	a_count_hold: assert property (@(posedge clk) disable iff (!rst_b)
		(!counting && !swCmd.countWrite && !hwReset) |=> $stable(period_count))
		else $error("count moved while halted");
	a_oneshot_run: assert property (@(posedge clk) disable iff (!rst_b)
		(tick && counting && match && clearRunAtMatch) |=> !timer_run_bit)
		else $error("run bit not cleared at match");
	a_mono_run: assert property (@(posedge clk) disable iff (!rst_b)
		(tick && counting && match && grp == period_timer_pkg::GRP_MONO && !sub[2]
		&& !swCmd.runClear && !swCmd.ctrlWrite) |=> timer_run_bit)
		else $error("monostable lost run bit");
	a_reserved_stop: assert property (@(posedge clk) disable iff (!rst_b)
		reserved && !swCmd.countWrite |=> $stable(period_count) && !postscaled_pulse)
		else $error("reserved mode counting");
	a_freeze_edges: assert property (@(posedge clk) disable iff (!rst_b)
		debugFreeze |-> !hwReset && !startEdge)
		else $error("trigger seen in freeze");
	a_flag_set: assert property (@(posedge clk) disable iff (!rst_b)
		postPulse |-> ##[1:2] period_irq_flag)
		else $error("flag not set after pulse");
	a_pulse_single: assert property (@(posedge clk) disable iff (!rst_b)
		postscaled_pulse && ctrl.prescale != 3'h0 |=> !postscaled_pulse)
		else $error("postscaled pulse too wide");
	a_scaler_clear: assert property (@(posedge clk) disable iff (!rst_b)
		swCmd.ctrlWrite |-> !tick ##1 !postscaled_pulse)
		else $error("scaler not cleared on write");
	c_oneshot_done: cover property (@(posedge clk) disable iff (!rst_b)
		timer_run_bit && clearRunAtMatch ##[1:300] !timer_run_bit);
	c_hw_reset: cover property (@(posedge clk) disable iff (!rst_b) hwReset);
	c_irq: cover property (@(posedge clk) disable iff (!rst_b) period_irq);
endmodule : period_timer_with_hw_limit

/* File: testbench/ext_trigger_model.sv */
/*
 * Far-side model of the sixteen external reset candidates seen by the timer.
 * Assumes the bench asks for a level on the selected candidate, and that the
 * prescaler runs 1:1 whenever triggers matter, so one clk is one timer clock.
 */
`timescale 1ns/100ps
module ext_trigger_model (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [3:0] sel,
	input wire logic wantLevel,
	output logic [15:0] sources
);
	// ---------------------------------------------------------------
	// selected source
	// ---------------------------------------------------------------
	logic level;
	logic [2:0] sinceChange;
	logic [15:0] noise;

	// a request is held back until six timer clocks passed since the last change
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			level <= 1'b0;
			sinceChange <= 3'h0;
		end else if (wantLevel != level && sinceChange >= 3'h6) begin
			level <= wantLevel;
			sinceChange <= 3'h0;
		end else if (sinceChange != 3'h7) begin
			sinceChange <= sinceChange + 3'h1;
		end
	end

	// unselected candidates toggle every cycle so a wrong pick cannot pass
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			noise <= 16'h5555;
		end else begin
			noise <= ~noise;
		end
	end

	always_comb begin
		sources = noise;
		sources[sel] = level;
	end
endmodule : ext_trigger_model

/* File: testbench/period_timer_with_hw_limit_tb_top.sv */
/*
 * Self-checking bench for the 8-bit period timer: software strobes, modes,
 * scalers and external triggers. Assumes the package and design files are
 * compiled first; inputs change on the falling edge of clk.
 */
`timescale 1ns/100ps
module period_timer_with_hw_limit_tb_top;
	logic clk;
	logic rst_b;
	period_timer_pkg::ctrl_s ctrl;
	period_timer_pkg::sw_s swCmd;
	logic [15:0] extSources;
	logic debugFreeze;
	logic wantLevel;
	logic [7:0] periodCount;
	logic [7:0] periodLimit;
	logic runBit;
	logic postPulse;
	logic irqFlag;
	logic irq;
	logic [7:0] c;
	int mismatches;
	int checks_done;
	int cycles;
	int np;
	int gap;

	period_timer_with_hw_limit u_dut (
		.clk(clk),
		.rst_b(rst_b),
		.ctrl(ctrl),
		.swCmd(swCmd),
		.ext_reset_sources(extSources),
		.debugFreeze(debugFreeze),
		.period_count(periodCount),
		.period_limit(periodLimit),
		.timer_run_bit(runBit),
		.postscaled_pulse(postPulse),
		.period_irq_flag(irqFlag),
		.period_irq(irq)
	);

	ext_trigger_model u_far (
		.clk(clk),
		.rst_b(rst_b),
		.sel(ctrl.source),
		.wantLevel(wantLevel),
		.sources(extSources)
	);

	// ---------------------------------------------------------------
	// clock, timeout and verdict
	// ---------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task tally_and_finish;
		if (mismatches == 0 && checks_done > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : tally_and_finish

	// the whole run needs about a thousand cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			tally_and_finish();
		end
	end

	// ---------------------------------------------------------------
	// access tasks
	// ---------------------------------------------------------------
	task step(input int n);
		repeat (n) @(negedge clk);
	endtask : step

	task check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	// strobe is dropped one cycle later, so back-to-back calls never collide
	task pulse_sw(input period_timer_pkg::sw_s cmd);
		swCmd = cmd;
		step(1);
		swCmd = '0;
		step(1);
	endtask : pulse_sw

	task write_count(input logic [7:0] v);
		period_timer_pkg::sw_s s;
		s = '0;
		s.countWrite = 1'b1;
		s.countData = v;
		pulse_sw(s);
	endtask : write_count

	task write_limit(input logic [7:0] v);
		period_timer_pkg::sw_s s;
		s = '0;
		s.limitWrite = 1'b1;
		s.limitData = v;
		pulse_sw(s);
	endtask : write_limit

	task set_ctrl(input logic run, input logic [4:0] mode);
		period_timer_pkg::sw_s s;
		s = '0;
		s.ctrlWrite = 1'b1;
		ctrl.run = run;
		ctrl.mode = mode;
		pulse_sw(s);
	endtask : set_ctrl

	task start(input logic [4:0] mode);
		set_ctrl(1'b0, mode);
		write_count(8'h00);
		set_ctrl(1'b1, mode);
	endtask : start

	task wait_count(input logic [7:0] exp, input int lim);
		int i;
		for (i = 0; i < lim && periodCount !== exp; i++) step(1);
		check("period_count", periodCount, exp);
	endtask : wait_count

	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	initial begin
		rst_b = 1'b0;
		ctrl = '0;
		ctrl.source = 4'h9;
		ctrl.irqEnable = 1'b1;
		swCmd = '0;
		debugFreeze = 1'b0;
		wantLevel = 1'b0;
		mismatches = 0;
		checks_done = 0;
		cycles = 0;
		repeat (5) @(negedge clk);
		rst_b = 1'b1;
		step(1);
		check("count at reset", periodCount, 8'h00);
		check("limit at reset", periodLimit, 8'hFF);
		check("flag at reset", {7'h00, irqFlag}, 8'h00);
		write_limit(8'h02);
		check("limit", periodLimit, 8'h02);
		set_ctrl(1'b1, 5'h00);
		wait_count(8'h02, 10);
		step(1);
		check("reload", periodCount, 8'h00);
		check("pulse", {7'h00, postPulse}, 8'h01);
		step(1);
		check("pulse width", {7'h00, postPulse}, 8'h00);
		check("count", periodCount, 8'h01);
		step(1);
		check("flag", {7'h00, irqFlag}, 8'h01);
		check("irq", {7'h00, irq}, 8'h01);
		ctrl.irqEnable = 1'b0;
		step(1);
		check("irq masked", {7'h00, irq}, 8'h00);
		set_ctrl(1'b0, 5'h00);
		pulse_sw('{flagClear: 1'b1, default: '0});
		check("flag cleared", {7'h00, irqFlag}, 8'h00);
		ctrl.irqEnable = 1'b1;
		c = periodCount;
		step(10);
		check("stopped", periodCount, c);
		write_limit(8'hFF);
		set_ctrl(1'b1, 5'h00);
		write_count(8'h10);
		check("count write", periodCount, 8'h11);
		c = periodCount;
		set_ctrl(1'b1, 5'h00);
		check("ctrl write keeps count", periodCount, c + 8'h01);
		for (int p = 0; p < 3; p++) begin
			ctrl.prescale = (p == 0) ? 3'h0 : (p == 1) ? 3'h2 : 3'h7;
			set_ctrl(1'b1, 5'h00);
			c = periodCount;
			for (gap = 0; gap < 300 && periodCount === c; gap++) step(1);
			c = periodCount;
			for (gap = 0; gap < 300 && periodCount === c; gap++) step(1);
			check("tick gap", 8'(gap), 8'(1 << ctrl.prescale));
		end
		ctrl.prescale = 3'h0;
		write_limit(8'h01);
		ctrl.postscale = 4'h3;
		start(5'h00);
		np = 0;
		for (int k = 0; k < 64; k++) begin
			step(1);
			np = np + ((postPulse === 1'b1) ? 1 : 0);
		end
		check("pulses per 64", 8'(np), 8'h08);
		ctrl.postscale = 4'h0;
		write_limit(8'hFF);
		for (int i = 0; i < 2; i++) begin
			wantLevel = (i == 0);
			step(8);
			start(5'(i + 1));
			step(5);
			wantLevel = (i != 0);
			step(10);
			c = periodCount;
			step(10);
			check("gated", periodCount, c);
			wantLevel = (i == 0);
			step(10);
			check("resumed", 8'(periodCount > c), 8'h01);
		end
		for (int i = 0; i < 3; i++) begin
			wantLevel = (i == 2);
			step(8);
			start(5'(i + 3));
			step(20);
			wantLevel = (i != 2);
			wait_count(8'h00, 12);
		end
		start(5'h04);
		step(8);
		debugFreeze = 1'b1;
		wantLevel = 1'b1;
		c = periodCount;
		step(12);
		check("frozen trigger", periodCount, c + 8'h0C);
		debugFreeze = 1'b0;
		wantLevel = 1'b0;
		step(8);
		start(5'h07);
		step(10);
		wantLevel = 1'b1;
		wait_count(8'h00, 12);
		step(10);
		check("held in reset", periodCount, 8'h00);
		set_ctrl(1'b0, 5'h07);
		write_count(8'h05);
		step(4);
		check("level ignored at rest", periodCount, 8'h05);
		set_ctrl(1'b1, 5'h07);
		wantLevel = 1'b0;
		step(12);
		check("released", 8'(periodCount != 8'h00), 8'h01);
		write_limit(8'h03);
		start(5'h08);
		wait_count(8'h03, 20);
		step(1);
		check("one-shot stop", periodCount, 8'h00);
		check("one-shot run", {7'h00, runBit}, 8'h00);
		step(10);
		check("no restart", periodCount, 8'h00);
		for (int i = 0; i < 2; i++) begin
			wantLevel = 1'b0;
			step(8);
			start((i == 0) ? 5'h09 : 5'h11);
			step(8);
			check("await edge", periodCount, 8'h00);
			wantLevel = 1'b1;
			wait_count(8'h03, 20);
			step(1);
			check("stop at zero", periodCount, 8'h00);
			check("run after match", {7'h00, runBit}, 8'(i));
		end
		wantLevel = 1'b0;
		step(8);
		wantLevel = 1'b1;
		wait_count(8'h03, 30);
		set_ctrl(1'b0, 5'h11);
		set_ctrl(1'b1, 5'h11);
		c = periodCount;
		step(8);
		check("fresh edge needed", periodCount, c);
		for (int i = 0; i < 3; i++) begin
			start((i == 0) ? 5'h10 : (i == 1) ? 5'h14 : 5'h18);
			wantLevel = !wantLevel;
			step(20);
			check("reserved idle", periodCount, 8'h00);
		end
		write_count(8'h5A);
		rst_b = 1'b0;
		step(2);
		check("limit after reset", periodLimit, 8'hFF);
		check("run after reset", {7'h00, runBit}, 8'h00);
		check("count after reset", periodCount, 8'h00);
		rst_b = 1'b1;
		step(2);
		tally_and_finish();
	end
endmodule : period_timer_with_hw_limit_tb_top
